// >>> src/timer_bus_pkg.sv
package timer_bus_pkg;

  localparam int          addr_width       = 12;
  localparam int          sub_count        = 4;
  localparam int          flag_count       = 8;

  // register byte addresses
  localparam logic [11:0] config_reg_addr  = 12'h000;
  localparam logic [11:0] test_reg_addr    = 12'h004;
  localparam logic [11:0] time_base_addr   = 12'h008;
  localparam logic [11:0] flag_reg_addr    = 12'h00c;
  localparam logic [11:0] int_ctrl_addr    = 12'h010;
  localparam logic [11:0] ack_reg_addr     = 12'h014;

  // configuration field positions
  localparam int          halt_bit         = 15;
  localparam int          freeze_bit       = 14;
  localparam int          vector_lsb       = 12;
  localparam int          select_lsb       = 8;
  localparam int          arb_lsb          = 0;

  localparam logic [15:0] config_reset     = 16'h0000;
  localparam logic [15:0] config_mask      = 16'hf307;
  localparam logic [7:0]  int_ctrl_reset   = 8'h00;
  localparam logic [2:0]  level_none       = 3'h0;

  typedef struct packed {
    logic       halt;
    logic       freeze_pass_enable;
    logic [1:0] vector_base_bits;
    logic [1:0] time_base_select;
    logic [2:0] arbitration_id;
  } config_type;

  typedef struct packed {
    logic [2:0] level;
    logic       arbitration_id_msb;
    logic [5:0] vector_low;
  } sub_int_type;

  typedef struct packed {
    logic       valid;
    logic [2:0] level;
    logic [3:0] arbitration;
    logic [7:0] vector;
  } ack_answer_type;

  typedef enum logic [1:0] {
    bus_idle,
    bus_write,
    bus_read
  } bus_state_type;

endpackage

// >>> src/flag_clear_cell.sv
`timescale 1ns/1ps
module flag_clear_cell
  import timer_bus_pkg::*;
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic set_event,
  input  wire logic read_strobe,
  input  wire logic write_zero,
  output logic      flag
);

  logic armed;

  // set wins over any clear in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flag <= 1'b0;
    end else if (set_event) begin
      flag <= 1'b1;
    end else if (write_zero && armed) begin
      flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      armed <= 1'b0;
    end else if (set_event) begin
      armed <= 1'b0;
    end else if (read_strobe && flag) begin
      armed <= 1'b1;
    end else if (write_zero) begin
      armed <= 1'b0;
    end
  end

endmodule

// >>> src/timer_bus_interface.sv
`timescale 1ns/1ps
module timer_bus_interface
  import timer_bus_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  input  wire logic                      hsel,
  input  wire logic [addr_width-1:0]     haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic      [31:0]               hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  input  wire logic                      bus_freeze,
  output logic                           submodule_freeze,
  input  wire logic [sub_count*16-1:0]   time_base_bus,
  input  wire logic [flag_count-1:0]     flag_set_event,
  output logic      [flag_count-1:0]     flag_state,
  input  wire logic [sub_count*10-1:0]   sub_int_request,
  output logic      [2:0]                int_level,
  input  wire logic                      interrupt_acknowledge_cycle,
  input  wire logic [2:0]                ack_level,
  output logic                           ack_valid,
  output logic      [3:0]                ack_arbitration,
  output logic      [7:0]                ack_vector
);

  config_type     cfg;
  logic [15:0]    test_reg;
  logic [7:0]     int_ctrl;
  ack_answer_type answer;
  ack_answer_type next_answer;
  bus_state_type  state;
  logic [11:0]    addr_q;
  logic           freeze_meta;
  logic           freeze_sync;
  logic           ack_meta;
  logic           ack_sync;
  logic [2:0]     next_level;
  logic [15:0]    time_base_word;
  logic [31:0]    next_rdata;
  logic           take;
  logic           flag_read;
  logic [flag_count-1:0] flag_zero;
  sub_int_type    req [sub_count];

  assign take      = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // the bus has one clock domain; clock stop halts all state with it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state  <= bus_idle;
      addr_q <= 12'h000;
    end else if (take) begin
      state  <= hwrite ? bus_write : bus_read;
      addr_q <= haddr;
    end else if (hready) begin
      state  <= bus_idle;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      freeze_meta <= 1'b0;
      freeze_sync <= 1'b0;
      ack_meta    <= 1'b0;
      ack_sync    <= 1'b0;
    end else begin
      freeze_meta <= bus_freeze;
      freeze_sync <= freeze_meta;
      ack_meta    <= interrupt_acknowledge_cycle;
      ack_sync    <= ack_meta;
    end
  end

  // configuration register write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg.halt               <= config_reset[halt_bit];
      cfg.freeze_pass_enable <= config_reset[freeze_bit];
      cfg.vector_base_bits   <= config_reset[vector_lsb+1:vector_lsb];
      cfg.time_base_select   <= config_reset[select_lsb+1:select_lsb];
      cfg.arbitration_id     <= config_reset[arb_lsb+2:arb_lsb];
    end else if (state == bus_write && addr_q == config_reg_addr) begin
      cfg.halt               <= hwdata[halt_bit];
      cfg.freeze_pass_enable <= hwdata[freeze_bit];
      cfg.vector_base_bits   <= hwdata[vector_lsb+1:vector_lsb];
      cfg.time_base_select   <= hwdata[select_lsb+1:select_lsb];
      cfg.arbitration_id     <= hwdata[arb_lsb+2:arb_lsb];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      test_reg <= 16'h0000;
    end else if (state == bus_write && addr_q == test_reg_addr) begin
      test_reg <= hwdata[15:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_ctrl <= int_ctrl_reset;
    end else if (state == bus_write && addr_q == int_ctrl_addr) begin
      int_ctrl <= hwdata[7:0];
    end
  end

  // halt forces freeze; otherwise freeze passes only when enabled
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      submodule_freeze <= 1'b0;
    end else begin
      submodule_freeze <= cfg.halt ||
        (cfg.freeze_pass_enable && freeze_sync);
    end
  end

  assign time_base_word =
    time_base_bus[cfg.time_base_select*16 +: 16];

  // status flags with read-then-zero-write clearing
  // arm at the edge that captures the read data, so arming matches what
  // software sees
  assign flag_read = take && !hwrite && haddr == flag_reg_addr;

  genvar g;
  generate
    for (g = 0; g < flag_count; g++) begin : g_flag
      assign flag_zero[g] = state == bus_write &&
        addr_q == flag_reg_addr && !hwdata[g];
      flag_clear_cell u_cell (
        .clk         (clk),
        .arst_n      (arst_n),
        .set_event   (flag_set_event[g]),
        .read_strobe (flag_read),
        .write_zero  (flag_zero[g]),
        .flag        (flag_state[g])
      );
    end
    for (g = 0; g < sub_count; g++) begin : g_req
      assign req[g] = sub_int_type'(sub_int_request[g*10 +: 10]);
    end
  endgenerate

  // highest requested level goes out on the bus
  always_comb begin
    next_level = level_none;
    for (int i = 0; i < sub_count; i++) begin
      if (req[i].level > next_level) begin
        next_level = req[i].level;
      end
    end
  end

  // acknowledge: matching level, highest arbitration number, first wins
  always_comb begin
    next_answer = '0;
    for (int i = 0; i < sub_count; i++) begin
      if (ack_sync && cfg.arbitration_id != 3'h0 &&
          req[i].level != level_none && req[i].level == ack_level &&
          (!next_answer.valid ||
           {req[i].arbitration_id_msb, cfg.arbitration_id} >
           next_answer.arbitration)) begin
        next_answer.valid       = 1'b1;
        next_answer.level       = req[i].level;
        next_answer.arbitration = {req[i].arbitration_id_msb,
                                   cfg.arbitration_id};
        next_answer.vector      = {cfg.vector_base_bits,
                                   req[i].vector_low};
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_level <= level_none;
      answer    <= '0;
    end else begin
      int_level <= next_level;
      answer    <= next_answer;
    end
  end

  assign ack_valid       = answer.valid;
  assign ack_arbitration = answer.arbitration;
  assign ack_vector      = answer.vector;

  // read data: unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (haddr == config_reg_addr) begin
      next_rdata[halt_bit]                    = cfg.halt;
      next_rdata[freeze_bit]                  = cfg.freeze_pass_enable;
      next_rdata[vector_lsb+1:vector_lsb]     = cfg.vector_base_bits;
      next_rdata[select_lsb+1:select_lsb]     = cfg.time_base_select;
      next_rdata[arb_lsb+2:arb_lsb]           = cfg.arbitration_id;
    end else if (haddr == test_reg_addr) begin
      next_rdata[15:0] = test_reg;
    end else if (haddr == time_base_addr) begin
      next_rdata[15:0] = time_base_word;
    end else if (haddr == flag_reg_addr) begin
      next_rdata[flag_count-1:0] = flag_state;
    end else if (haddr == int_ctrl_addr) begin
      next_rdata[7:0] = int_ctrl;
    end else if (haddr == ack_reg_addr) begin
      next_rdata[15:0] = answer;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

endmodule

// >>> bench/timer_bus_interface_assertions.sv
`timescale 1ns/1ps
module timer_bus_checker
  import timer_bus_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  arst_n,
  input wire logic                  hsel,
  input wire logic [addr_width-1:0] haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic [31:0]           hwdata,
  input wire logic                  hready,
  input wire logic [31:0]           hrdata,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic                  bus_freeze,
  input wire logic                  submodule_freeze,
  input wire logic [flag_count-1:0] flag_set_event,
  input wire logic [flag_count-1:0] flag_state,
  input wire logic                  interrupt_acknowledge_cycle,
  input wire logic                  ack_valid
);
  logic                  wr_dp;
  logic [addr_width-1:0] wr_addr;
  logic                  halt;
  logic                  pass;
  logic [flag_count-1:0] clr_ok;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // track the write data phase and the config bits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_dp <= 1'b0;
      wr_addr <= '0;
      halt <= 1'b0;
      pass <= 1'b0;
      clr_ok <= '0;
    end else begin
      wr_dp <= hsel && hready && htrans[1] && hwrite;
      wr_addr <= haddr;
      clr_ok <= '0;
      if (wr_dp && wr_addr == config_reg_addr) begin
        halt <= hwdata[halt_bit];
        pass <= hwdata[freeze_bit];
      end
      if (wr_dp && wr_addr == flag_reg_addr) begin
        clr_ok <= ~hwdata[flag_count-1:0];
      end
    end
  end
  sequence freeze_off_held;
    (!halt && !pass) [*3];
  endsequence
  sequence freeze_on_held;
    (pass && bus_freeze) [*4];
  endsequence
  okay_resp_a: assert property (hreadyout && !hresp)
    else $error("slave not ready or response not okay");
  read_hold_a: assert property (
    !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data moved");
  freeze_ignored_a: assert property (
    freeze_off_held |=> !submodule_freeze)
    else $error("freeze passed while disabled");
  freeze_passed_a: assert property (
    freeze_on_held |=> submodule_freeze)
    else $error("freeze not passed");
  halt_forces_a: assert property (halt [*2] |=> submodule_freeze)
    else $error("halt did not freeze");
  flag_clear_a: assert property (
    ($past(flag_state) & ~flag_state & ~clr_ok) == '0)
    else $error("flag cleared wrongly");
  flag_event_a: assert property (|flag_set_event |=>
    (flag_state & $past(flag_set_event)) == $past(flag_set_event))
    else $error("set event lost");
  ack_idle_a: assert property (
    !interrupt_acknowledge_cycle [*3] |=> !ack_valid)
    else $error("answer without acknowledge");
endmodule
bind timer_bus_interface timer_bus_checker timer_bus_checker_i (.*);

// >>> bench/ahb_master_model.sv
`timescale 1ns/1ps
module ahb_master_model (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [11:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // bounded wait for hready at a rising edge
  task automatic await;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      timer_bus_interface_test.fail_count++;
      timer_bus_interface_test.finish_test();
    end
  endtask
  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    await();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    await();
    r = hrdata;
    hwdata <= ~d;
  endtask
endmodule

// >>> bench/timer_bus_interface_test.sv
`timescale 1ns/1ps
module timer_bus_interface_test;
  import timer_bus_pkg::*;
  logic clk, arst_n, hsel, hwrite, hready, hresp, bus_freeze, sub_frz;
  logic ack, ack_valid;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize, int_level, ack_level;
  logic [31:0] hwdata, hrdata, rdata;
  logic [63:0] tb_bus;
  logic [7:0] flag_ev, flag_state, ack_vector;
  logic [39:0] req;
  logic [3:0] ack_arb;
  int fail_count, checked;
  timer_bus_interface timer_bus_interface_i (.clk(clk), .arst_n(arst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .bus_freeze(bus_freeze),
    .submodule_freeze(sub_frz), .time_base_bus(tb_bus),
    .flag_set_event(flag_ev), .flag_state(flag_state),
    .sub_int_request(req), .int_level(int_level),
    .interrupt_acknowledge_cycle(ack), .ack_level(ack_level),
    .ack_valid(ack_valid), .ack_arbitration(ack_arb),
    .ack_vector(ack_vector));
  ahb_master_model ahb_master_model_i (.clk(clk), .hready(hready),
    .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    ahb_master_model_i.xfer(a, 1'b1, d, rdata);
    @(negedge clk);
  endtask
  task automatic rd(input logic [11:0] a);
    ahb_master_model_i.xfer(a, 1'b0, 32'h0, rdata);
  endtask
  task automatic drive_ack(input logic v);
    @(posedge clk);
    ack <= v;
    settle(4);
  endtask
  task automatic regs_scenario;
    rd(config_reg_addr);
    check(rdata, 32'h0);
    wr(config_reg_addr, 32'hffffffff);
    rd(config_reg_addr);
    check(rdata, {16'h0, config_mask});
    wr(test_reg_addr, 32'h0000a5c3);
    rd(test_reg_addr);
    check(rdata, 32'h0000a5c3);
    wr(int_ctrl_addr, 32'h000000a5);
    rd(int_ctrl_addr);
    check(rdata, 32'h000000a5);
    wr(12'h0f0, 32'h12345678);
    rd(12'h0f0);
    check(rdata, 32'h0);
  endtask
  task automatic freeze_scenario;
    wr(config_reg_addr, 32'h0);
    @(posedge clk);
    bus_freeze <= 1'b1;
    settle(5);
    check({31'h0, sub_frz}, 32'h0);
    wr(config_reg_addr, 32'h1 << freeze_bit);
    settle(3);
    check({31'h0, sub_frz}, 32'h1);
    @(posedge clk);
    bus_freeze <= 1'b0;
    wr(config_reg_addr, 32'h1 << halt_bit);
    settle(3);
    check({31'h0, sub_frz}, 32'h1);
    rd(config_reg_addr);
    check(rdata, 32'h1 << halt_bit);
    wr(config_reg_addr, 32'h0);
    settle(3);
    check({31'h0, sub_frz}, 32'h0);
  endtask
  task automatic time_base_scenario;
    for (int k = 0; k < 4; k++) begin
      wr(config_reg_addr, k << select_lsb);
      rd(time_base_addr);
      check(rdata, {16'h0, tb_bus[16*k +: 16]});
    end
  endtask
  task automatic pulse(input logic [7:0] v);
    @(posedge clk);
    flag_ev <= v;
    @(posedge clk);
    flag_ev <= 8'h00;
  endtask
  task automatic flag_scenario;
    pulse(8'h03);
    wr(flag_reg_addr, 32'h0);
    check({24'h0, flag_state}, 32'h3);
    rd(flag_reg_addr);
    check(rdata, 32'h3);
    wr(flag_reg_addr, 32'hff);
    check({24'h0, flag_state}, 32'h3);
    pulse(8'h02);
    wr(flag_reg_addr, 32'h0);
    check({24'h0, flag_state}, 32'h2);
    rd(flag_reg_addr);
    wr(flag_reg_addr, 32'h0);
    check({24'h0, flag_state}, 32'h0);
  endtask
  task automatic irq_scenario;
    @(posedge clk);
    req <= {10'h0, 3'd5, 1'b0, 6'h2a, 3'd5, 1'b1, 6'h15, 10'h0};
    ack_level <= 3'd5;
    wr(config_reg_addr, 32'h2003);
    check({29'h0, int_level}, 32'h5);
    drive_ack(1'b1);
    check({19'h0, ack_valid, ack_arb, ack_vector}, 32'h1b95);
    rd(ack_reg_addr);
    check(rdata, 32'h0000db95);
    drive_ack(1'b0);
    check({31'h0, ack_valid}, 32'h0);
    wr(config_reg_addr, 32'h3000);
    drive_ack(1'b1);
    check({31'h0, ack_valid}, 32'h0);
    drive_ack(1'b0);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    arst_n = 1'b0;
    bus_freeze = 1'b0;
    tb_bus = 64'hd4c4_b3a3_9282_7161;
    flag_ev = 8'h00;
    req = 40'h0;
    ack = 1'b0;
    ack_level = 3'h0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    regs_scenario();
    freeze_scenario();
    time_base_scenario();
    flag_scenario();
    irq_scenario();
    finish_test();
  end
endmodule
